// file: tb_top.sv
// tb_top: self-checking bench for tmd_top over axi4-lite and mode pins.
// assumes a 40 MHz aclk and the controller model on the pins.
`timescale 1ns/10ps
module tb_top;
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic [7:0]            s_axi_awaddr = 8'h00;
	logic                  s_axi_awvalid = 1'b0;
	logic                  s_axi_awready;
	logic [31:0]           s_axi_wdata = 32'h0;
	logic [3:0]            s_axi_wstrb = 4'hf;
	logic                  s_axi_wvalid = 1'b0;
	logic                  s_axi_wready;
	logic [1:0]            s_axi_bresp;
	logic                  s_axi_bvalid;
	logic                  s_axi_bready = 1'b0;
	logic [7:0]            s_axi_araddr = 8'h00;
	logic                  s_axi_arvalid = 1'b0;
	logic                  s_axi_arready;
	logic [31:0]           s_axi_rdata;
	logic [1:0]            s_axi_rresp;
	logic                  s_axi_rvalid;
	logic                  s_axi_rready = 1'b0;
	tmd_pkg::tmd_pins_s    pins;
	tmd_pkg::tmd_enables_s enables;
	tmd_pkg::tmd_clk_cfg_s clk_cfg;
	logic [1:0]            pa_bias_req;
	int                    errors = 0;
	int                    cmp_count = 0;
	logic [31:0]           rv;
	logic [1:0]            rr;

	always #12.5 aclk = ~aclk;
	tmd_top u_dut (.*);
	tmd_ctl_model u_ctl (.aclk(aclk), .pins(pins));

	task automatic results;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic hang(input int n);
		if (n >= 64) begin
			errors++;
			results();
		end
	endtask : hang

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			rr = s_axi_bresp;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		hang(n);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		hang(n);
	endtask : rd

	task automatic pin(input logic e, input logic d, input logic c);
		u_ctl.drive(e, d, c);
		repeat (2) @(posedge aclk);
	endtask : pin

	// entry = {field, enable, direction, clock enable, mode code}
	task automatic s_modes;
		logic [7:0] t [12];
		t = '{8'h00, 8'h09, 8'h52, 8'h5a, 8'h73, 8'h6c, 8'he5, 8'hfe,
			8'h89, 8'hb0, 8'h30, 8'hd0};
		for (int i = 0; i < 12; i++) begin
			wr(tmd_pkg::OFF_MAIN22, {30'h0, t[i][7:6]});
			pin(t[i][5], t[i][4], t[i][3]);
			rd(tmd_pkg::OFF_STATUS);
			chk(rv, {29'h0, t[i][2:0]});
			chk(enables.divided_reference_output, t[i][3]);
			chk(enables.synth_vco, t[i][2:0] > 3'h1);
		end
	endtask : s_modes

	task automatic s_paths;
		for (int b = 0; b < 2; b++) begin
			wr(tmd_pkg::OFF_MAIN0, {26'h0, b[0], 5'h0});
			wr(tmd_pkg::OFF_MAIN22, {29'h0, b[0], 2'h1});
			pin(1'b1, 1'b1, 1'b0);
			chk({enables.receiver_a, enables.receiver_b}, {1'b1, b[0]});
			pin(1'b1, 1'b0, 1'b0);
			chk({enables.transmitter_a, enables.transmitter_b,
				enables.tx_pa_driver}, {1'b1, b[0], 1'b1});
		end
	endtask : s_paths

	task automatic s_cal;
		wr(tmd_pkg::OFF_MAIN0, 32'h0);
		wr(tmd_pkg::OFF_MAIN6, 32'h200);
		for (int s = 0; s < 2; s++) begin
			wr(tmd_pkg::OFF_MAIN22, {28'h0, s[0], 3'h3});
			pin(1'b1, 1'b0, 1'b0);
			chk({enables.transmitter_a, enables.transmitter_b,
				enables.cal_target_tx_a}, {s[0], !s[0], s[0]});
			chk({enables.tx_pa_driver, enables.am_detector,
				enables.rx_iq_buffers, enables.receiver_a}, 4'h6);
			chk(enables.amdet_to_rx_baseband, 1'b1);
		end
		pin(1'b1, 1'b1, 1'b0);
		chk({enables.rx_lna, enables.loopback, enables.receiver_a,
			enables.tx_pa_driver, enables.transmitter_a}, 5'h0d);
		chk(enables.amdet_to_rx_baseband, 1'b1);
		wr(tmd_pkg::OFF_MAIN6, 32'h0);
		repeat (2) @(posedge aclk);
		chk(enables.amdet_to_rx_baseband, 1'b0);
	endtask : s_cal

	task automatic s_pab;
		wr(tmd_pkg::OFF_PIN_CTRL, 32'h3);
		rd(tmd_pkg::OFF_PIN_CTRL);
		chk(rv, 32'h3);
		chk(pa_bias_req, 2'h3);
		wr(tmd_pkg::OFF_MAIN22, 32'h1);
		pin(1'b0, 1'b1, 1'b0);
		chk({enables.pa_bias_a, enables.pa_bias_b}, 2'h3);
		wr(tmd_pkg::OFF_MAIN22, 32'h0);
		pin(1'b0, 1'b0, 1'b1);
		chk({enables.pa_bias_a, enables.pa_bias_b}, 2'h0);
	endtask : s_pab

	task automatic s_clk;
		logic [3:0] lv [2];
		lv = '{4'h6, 4'h9};
		for (int k = 0; k < 2; k++) begin
			u_ctl.clk_setup(lv[k]);
			repeat (3) @(posedge aclk);
			chk(clk_cfg, lv[k]);
			pin(!lv[k][2], !lv[k][3], 1'b1);
			rd(tmd_pkg::OFF_CLK_CFG);
			chk(rv, {27'h0, 1'b1, lv[k]});
		end
	endtask : s_clk

	task automatic s_bad;
		rd(8'h40);
		chk(rr, tmd_pkg::RESP_SLVERR);
		chk(rv, 32'h0);
		wr(8'h40, 32'h3ff);
		chk(rr, tmd_pkg::RESP_SLVERR);
		wr(tmd_pkg::OFF_MAIN0, 32'h200);
		wr(tmd_pkg::OFF_MAIN22, 32'h155);
		rd(tmd_pkg::OFF_LOCAL_BASE);
		chk(rv, 32'h155);
		rd(tmd_pkg::OFF_MAIN22);
		chk(rv, 32'h0);
		rd(tmd_pkg::OFF_SERIAL);
		chk(rv, 32'h200);
	endtask : s_bad

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(tmd_pkg::OFF_CLK_CFG);
		chk(rv, 32'h10);
		s_modes();
		s_paths();
		s_cal();
		s_pab();
		s_clk();
		s_bad();
		results();
	end
endmodule : tb_top

// file: tmd_assertions.sv
// tmd_assertions: port-level checks for tmd_top.
// assumes rising aclk and synchronous active-low aresetn.
`timescale 1ns/10ps
module tmd_assertions (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic [31:0]           s_axi_rdata,
	input wire tmd_pkg::tmd_pins_s    pins,
	input wire tmd_pkg::tmd_enables_s enables,
	input wire tmd_pkg::tmd_clk_cfg_s clk_cfg
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	clk_follow_a: assert property ($past(aresetn) |->
		enables.divided_reference_output == $past(pins.clock_output_enable))
		else $error("clock output does not follow its enable");
	quiet_off_a: assert property ($past(aresetn) &&
		!$past(pins.enable) && !$past(pins.path_direction_select) |->
		!enables.synth_vco && !enables.receiver_a && !enables.transmitter_a)
		else $error("paths powered with both mode pins low");
	pab_off_a: assert property ($past(aresetn) &&
		!$past(pins.enable) && !$past(pins.path_direction_select) |->
		!enables.pa_bias_a && !enables.pa_bias_b)
		else $error("pa bias on in shutdown or clock-out");
	cal_driver_a: assert property (
		enables.am_detector || enables.loopback |->
		!enables.tx_pa_driver && !(enables.loopback && enables.rx_lna))
		else $error("driver or lna on during calibration");
	rx_both_a: assert property (enables.receiver_b |-> enables.receiver_a)
		else $error("receiver b without receiver a");
	tx_both_a: assert property (
		enables.transmitter_b && !enables.am_detector |-> enables.transmitter_a)
		else $error("transmitter b without transmitter a");
	cfg_capture_a: assert property (
		$changed(clk_cfg) && $past(aresetn) && $past(aresetn, 2) |->
		$past(pins.clock_output_enable) && !$past(pins.clock_output_enable, 2))
		else $error("clock config changed without enable rise");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped before taken");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	rvalid_take_a: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid)
		else $error("read answer repeated after it was taken");
endmodule : tmd_assertions

bind tmd_top tmd_assertions u_chk (.*);

// file: tmd_ctl_model.sv
// tmd_ctl_model: baseband controller side, drives the mode pins.
// assumes levels change just after a rising aclk edge.
`timescale 1ns/10ps
module tmd_ctl_model (
	input  wire logic          aclk,
	output tmd_pkg::tmd_pins_s pins
);
	initial pins = '0;

	// mode pins only; serial lines keep their levels
	task automatic drive(input logic e, input logic d, input logic c);
		@(posedge aclk);
		pins.enable                <= e;
		pins.path_direction_select <= d;
		pins.clock_output_enable   <= c;
	endtask : drive

	// lv = {pds, en, cs, sdi}, settled one edge before the rise
	task automatic clk_setup(input logic [3:0] lv);
		@(posedge aclk);
		pins <= {lv[2], lv[3], 1'b0, lv[0], lv[1]};
		@(posedge aclk);
		pins.clock_output_enable <= 1'b1;
	endtask : clk_setup
endmodule : tmd_ctl_model

// file: tmd_mode_decode.sv
// tmd_mode_decode: combinational mode decode from pins and register bits.
// assumes pin levels already synchronous to the system clock.
`timescale 1ns/10ps
module tmd_mode_decode (
	input  wire logic [1:0]           mode_field,
	input  wire tmd_pkg::tmd_pins_s   pins,
	input  wire logic                 both_rx,
	input  wire logic                 both_tx,
	input  wire logic                 tx_cal_sel_a,
	input  wire logic                 amdet_route,
	input  wire logic [1:0]           pa_bias_req,
	output tmd_pkg::tmd_mode_e        mode,
	output tmd_pkg::tmd_enables_s     en
);

	always_comb begin
		// 10 behaves as 00 [R3]
		logic [1:0] mf;
		mf = (mode_field == tmd_pkg::MF_UNUS) ? tmd_pkg::MF_OFF : mode_field;
		mode = tmd_pkg::MODE_SHUTDOWN; // unlisted combos [R17]
		if (mf == tmd_pkg::MF_OFF && !pins.enable &&
		    !pins.path_direction_select) begin // [R1]
			mode = pins.clock_output_enable ? tmd_pkg::MODE_DIVIDED_REFERENCE_OUTPUT
				: tmd_pkg::MODE_SHUTDOWN;
		end else if (mf == tmd_pkg::MF_ON) begin // cken ignored [R16]
			if (!pins.enable && pins.path_direction_select)
				mode = tmd_pkg::MODE_STANDBY;
			else if (pins.enable)
				mode = pins.path_direction_select ? tmd_pkg::MODE_RX
					: tmd_pkg::MODE_TX;
		end else if (mf == tmd_pkg::MF_CAL && pins.enable) begin
			mode = pins.path_direction_select ? tmd_pkg::MODE_RXCAL
				: tmd_pkg::MODE_TXCAL;
		end
	end

	always_comb begin
		en = '0;
		// clock output follows its pin in every mode [R4]
		en.divided_reference_output = pins.clock_output_enable;
		unique case (mode)
			tmd_pkg::MODE_SHUTDOWN, tmd_pkg::MODE_DIVIDED_REFERENCE_OUTPUT: begin
				// pa bias forced off [R6]
			end
			tmd_pkg::MODE_STANDBY: begin
				en.synth_vco = 1'b1;
			end
			tmd_pkg::MODE_RX: begin
				en.synth_vco  = 1'b1;
				en.receiver_a = 1'b1;
				en.receiver_b = both_rx; // [R7]
				en.rx_lna     = 1'b1;
			end
			tmd_pkg::MODE_TX: begin
				en.synth_vco     = 1'b1;
				en.transmitter_a = 1'b1;
				en.transmitter_b = both_tx; // [R8]
				en.tx_pa_driver  = 1'b1;
			end
			tmd_pkg::MODE_TXCAL: begin
				en.synth_vco       = 1'b1;
				en.transmitter_a   = tx_cal_sel_a; // [R10]
				en.transmitter_b   = !tx_cal_sel_a; // [R10]
				en.cal_target_tx_a = tx_cal_sel_a;
				en.am_detector     = 1'b1; // [R2]
				en.rx_iq_buffers   = 1'b1; // [R2]
				// detector results on rx baseband lines [R11]
				en.amdet_to_rx_baseband = 1'b1;
			end
			tmd_pkg::MODE_RXCAL: begin
				en.synth_vco     = 1'b1;
				en.receiver_a    = 1'b1; // lna stays off [R2]
				en.receiver_b    = both_rx;
				en.transmitter_a = 1'b1; // pa driver off [R2]
				en.loopback      = 1'b1; // [R2]
			end
		endcase
		// am detector routing by register bit [R9]
		if (amdet_route && mode != tmd_pkg::MODE_SHUTDOWN &&
		    mode != tmd_pkg::MODE_DIVIDED_REFERENCE_OUTPUT)
			en.amdet_to_rx_baseband = 1'b1;
		if (mode != tmd_pkg::MODE_SHUTDOWN &&
		    mode != tmd_pkg::MODE_DIVIDED_REFERENCE_OUTPUT) begin // [R6]
			en.pa_bias_a = pa_bias_req[tmd_pkg::PAB_A_POS];
			en.pa_bias_b = pa_bias_req[tmd_pkg::PAB_B_POS];
		end
	end

endmodule : tmd_mode_decode

// file: tmd_pkg.sv
// tmd_pkg: shared constants and carrier structs for the transceiver mode
// decoder. assumes 16-bit serial words with 10-bit register data.
package tmd_pkg;

	// register bus offsets (byte addresses, one word each)
	localparam logic [7:0] OFF_MAIN0      = 8'h00;
	localparam logic [7:0] OFF_MAIN6      = 8'h04;
	localparam logic [7:0] OFF_MAIN22     = 8'h08;
	localparam logic [7:0] OFF_PIN_CTRL   = 8'h0c;
	localparam logic [7:0] OFF_STATUS     = 8'h10;
	localparam logic [7:0] OFF_CLK_CFG    = 8'h14;
	localparam logic [7:0] OFF_SERIAL     = 8'h18;
	localparam logic [7:0] OFF_LOCAL_BASE = 8'h80;

	// serial word layout
	localparam int WORD_BITS = 16;
	localparam int RW_POS    = 15;
	localparam int ADDR_MSB  = 14;
	localparam int ADDR_LSB  = 10;
	localparam int DATA_BITS = 10;

	// field positions
	localparam int MAIN0_BANK_POS = 9;
	localparam int MAIN0_MIMO_POS = 5;
	localparam int MAIN6_AMDET_POS = 9;
	localparam int MAIN22_TXCAL_POS = 3;
	localparam int MAIN22_TXBOTH_POS = 2;
	localparam int MAIN22_MODE_MSB = 1;
	localparam int MAIN22_MODE_LSB = 0;
	localparam int PAB_A_POS = 0;
	localparam int PAB_B_POS = 1;

	localparam logic [4:0] MAIN0_ADDR  = 5'h00;
	localparam logic [4:0] MAIN6_ADDR  = 5'h06;
	localparam logic [4:0] MAIN22_ADDR = 5'h16;

	// mode field codes
	localparam logic [1:0] MF_OFF  = 2'h0;
	localparam logic [1:0] MF_ON   = 2'h1;
	localparam logic [1:0] MF_UNUS = 2'h2;
	localparam logic [1:0] MF_CAL  = 2'h3;

	// reset values
	localparam logic [9:0] REG_RST = 10'h000;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MODE_SHUTDOWN,
		MODE_DIVIDED_REFERENCE_OUTPUT,
		MODE_STANDBY,
		MODE_RX,
		MODE_TX,
		MODE_TXCAL,
		MODE_RXCAL
	} tmd_mode_e;

	typedef struct packed {
		logic enable;
		logic path_direction_select;
		logic clock_output_enable;
		logic serial_data_in;
		logic chip_select;
	} tmd_pins_s;

	typedef struct packed {
		logic receiver_a;
		logic receiver_b;
		logic rx_lna;
		logic transmitter_a;
		logic transmitter_b;
		logic tx_pa_driver;
		logic synth_vco;
		logic divided_reference_output;
		logic am_detector;
		logic rx_iq_buffers;
		logic loopback;
		logic amdet_to_rx_baseband;
		logic cal_target_tx_a;
		logic pa_bias_a;
		logic pa_bias_b;
	} tmd_enables_s;

	typedef struct packed {
		logic divide_by_two;
		logic xtal_osc_enable;
		logic [1:0] xtal_freq_sel;
	} tmd_clk_cfg_s;

endpackage : tmd_pkg

// file: tmd_top.sv
// tmd_top: transceiver mode decoder with axi4-lite register access.
// assumes pins synchronous to aclk; one write and one read at a time.
//
// Behaviour
// R1: mode from field, enable, direction select, clock-output enable per table.
// R2: calibration modes power listed partial paths, detector, buffers or loopback.
// R3: controller avoids field 10; device treats 10 as 00.
// R4: clock output follows clock-output enable in every mode.
// R5: divide ratio and oscillator enable captured at power-up or enable rise.
// R6: pa bias selectable except in shutdown and clock-out-only.
// R7: receive mode enables receiver b only when main0 bit 5 set.
// R8: transmit mode enables transmitter b only when main22 bit 2 set.
// R9: main6 bit 9 routes am detector onto receive baseband outputs.
// R10: tx calibration targets transmitter a when main22 bit 3 set, else b.
// R11: tx calibration presents leakage detector results on receive baseband.
// R12: controller holds config pin levels while raising clock-output enable.
// R13: after capture edge, pin changes leave clock configuration alone.
// R14: serial word is 16 bits: rw, five address bits, ten data.
// R15: main0 bit 9 selects main or local register bank.
// R16: clock-output enable ignored in active modes; decode is combinational (enables output here registered, one aclk behind the pins).
// R17: unlisted combinations decode as shutdown.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module tmd_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire tmd_pkg::tmd_pins_s   pins,
	output tmd_pkg::tmd_enables_s     enables,
	output tmd_pkg::tmd_clk_cfg_s     clk_cfg,
	output logic [1:0]                pa_bias_req
);

	typedef struct packed {
		logic [9:0]            main0;
		logic [9:0]            main6;
		logic [9:0]            main22;
		logic [1:0]            pab;
		logic [9:0]            local0;
		logic [15:0]           last_word;
		logic                  aw_hold;
		logic [7:0]            aw_addr;
		logic                  w_hold;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic                  cken_d;
		logic                  cfg_done;
		tmd_pkg::tmd_clk_cfg_s cfg;
		tmd_pkg::tmd_enables_s en;
	} tmd_state_s;

	tmd_state_s            st;
	tmd_state_s            next_st;
	tmd_pkg::tmd_mode_e    mode;
	tmd_pkg::tmd_enables_s dec_en;

	tmd_mode_decode u_dec (
		.mode_field   (st.main22[tmd_pkg::MAIN22_MODE_MSB:
			tmd_pkg::MAIN22_MODE_LSB]),
		.pins         (pins),
		.both_rx      (st.main0[tmd_pkg::MAIN0_MIMO_POS]), // [R7]
		.both_tx      (st.main22[tmd_pkg::MAIN22_TXBOTH_POS]), // [R8]
		.tx_cal_sel_a (st.main22[tmd_pkg::MAIN22_TXCAL_POS]), // [R10]
		.amdet_route  (st.main6[tmd_pkg::MAIN6_AMDET_POS]), // [R9]
		.pa_bias_req  (st.pab),
		.mode         (mode),
		.en           (dec_en)
	);

	// register write of one 10-bit field into the register chosen by
	// the bank select, mimicking a 16-bit serial word [R14]
	function automatic logic [9:0] merge(input logic [9:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [9:0] r;
		r = old;
		if (s[0])
			r[7:0] = d[7:0];
		if (s[1])
			r[9:8] = d[9:8];
		return r;
	endfunction : merge

	always_comb begin
		logic       hit;
		logic [9:0] rd;
		next_st = st;
		hit     = 1'b1;
		rd      = '0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_hold = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_hold = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.aw_hold && st.w_hold && !st.bvalid) begin
			next_st.aw_hold = 1'b0;
			next_st.w_hold  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = tmd_pkg::RESP_OKAY;
			unique case (st.aw_addr)
				tmd_pkg::OFF_MAIN0: begin
					next_st.main0 = merge(st.main0, st.w_data, st.w_strb);
					next_st.last_word = {1'b0, tmd_pkg::MAIN0_ADDR,
						next_st.main0};
				end
				tmd_pkg::OFF_MAIN6:
					// main bank only while bank select is clear [R15]
					if (!st.main0[tmd_pkg::MAIN0_BANK_POS]) begin
						next_st.main6 = merge(st.main6, st.w_data, st.w_strb);
						next_st.last_word = {1'b0, tmd_pkg::MAIN6_ADDR,
							next_st.main6};
					end else
						next_st.local0 = merge(st.local0, st.w_data,
							st.w_strb);
				tmd_pkg::OFF_MAIN22:
					if (!st.main0[tmd_pkg::MAIN0_BANK_POS]) begin // [R15]
						next_st.main22 = merge(st.main22, st.w_data,
							st.w_strb);
						next_st.last_word = {1'b0, tmd_pkg::MAIN22_ADDR,
							next_st.main22};
					end else
						next_st.local0 = merge(st.local0, st.w_data,
							st.w_strb);
				tmd_pkg::OFF_PIN_CTRL:
					if (st.w_strb[0])
						next_st.pab = st.w_data[1:0];
				tmd_pkg::OFF_STATUS, tmd_pkg::OFF_CLK_CFG,
				tmd_pkg::OFF_SERIAL, tmd_pkg::OFF_LOCAL_BASE: begin
				end
				default:
					next_st.bresp = tmd_pkg::RESP_SLVERR;
			endcase
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;

		if (s_axi_arvalid && s_axi_arready) begin
			unique case (s_axi_araddr)
				tmd_pkg::OFF_MAIN0:      rd = st.main0;
				tmd_pkg::OFF_MAIN6:      rd = st.main6;
				tmd_pkg::OFF_MAIN22:     rd = st.main22;
				tmd_pkg::OFF_PIN_CTRL:   rd = {8'h00, st.pab};
				tmd_pkg::OFF_STATUS:     rd = {7'h00, 3'(mode)};
				tmd_pkg::OFF_CLK_CFG:    rd = {5'h00, st.cfg_done, st.cfg};
				tmd_pkg::OFF_LOCAL_BASE: rd = st.local0;
				tmd_pkg::OFF_SERIAL:     rd = '0;
				default:                 hit = 1'b0;
			endcase
			next_st.rvalid = 1'b1;
			next_st.rdata  = (s_axi_araddr == tmd_pkg::OFF_SERIAL)
				? {16'h0000, st.last_word} : {22'h000000, rd};
			next_st.rresp  = hit ? tmd_pkg::RESP_OKAY : tmd_pkg::RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end

		// capture clock config on the enable rise, or once after reset
		// as the power-up capture; later pin changes ignored [R5] [R13]
		next_st.cken_d = pins.clock_output_enable;
		if (!st.cfg_done ||
		    (pins.clock_output_enable && !st.cken_d)) begin // [R5]
			next_st.cfg_done = 1'b1;
			next_st.cfg.divide_by_two   = pins.path_direction_select;
			next_st.cfg.xtal_osc_enable = pins.enable;
			next_st.cfg.xtal_freq_sel   = {pins.chip_select,
				pins.serial_data_in};
		end
		next_st.en = dec_en; // [R16]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st        <= '0;
			st.main0  <= tmd_pkg::REG_RST;
			st.main6  <= tmd_pkg::REG_RST;
			st.main22 <= tmd_pkg::REG_RST;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = !st.aw_hold;
	assign s_axi_wready  = !st.w_hold;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign enables       = st.en;
	assign clk_cfg       = st.cfg;
	assign pa_bias_req   = st.pab;

endmodule : tmd_top
